// ### hw/cache_tune_cfg.svh
/*
 * Named constants for the cache tuning, lock-stack and diagnostic block:
 * register offsets, field positions, reset values and widths.
 * Assumes it is included by bare name from hw/ and holds no logic.
 */
`ifndef CACHE_TUNE_CFG_SVH
`define CACHE_TUNE_CFG_SVH

// register offsets on the special-register port
`define OFS_FLASH_STATUS 8'h88
`define OFS_CACHE_TUNING 8'ha2
`define OFS_CACHE_LOCK_CONTROL 8'ha3
`define OFS_CACHE_MISS_ACC 8'h9a

// reset values
`define RST_FLASH_STATUS 8'h00
`define RST_CACHE_TUNING 8'h04
`define RST_CACHE_LOCK_CONTROL 8'h3e
`define RST_CACHE_MISS_ACC 8'h00

// cache_tuning fields
`define TUN_ALGO_BIT 3
`define TUN_FIX_BIT 2
`define TUN_THR_HI 1
`define TUN_THR_LO 0
`define TUN_LOWF_HI 7
`define TUN_LOWF_LO 4

// cache_lock_control fields
`define LCK_PUSH_BIT 7
`define LCK_POP_BIT 6
`define LCK_PTR_HI 5
`define LCK_PTR_LO 0

// cache_miss_accumulator fields
`define MA_OV_BIT 7
`define MA_HIGH_HI 6
`define MA_HIGH_LO 0

// flash_status fields
`define FS_BUSY_BIT 0

// accumulator geometry
`define ACC_W 12
`define ACC_MAX 12'hfff
`define ACC_HIGH_HI 11
`define ACC_HIGH_LO 5
`define ACC_LOWF_HI 4
`define ACC_LOWF_LO 1
`define ACC_CLR_BITS 5

// cache geometry and pointers
`define SLOT_W 6
`define SLOT_LAST 6'h3e
`define SLOT_ZERO 6'h00
`define SLOT_ONE 6'h01
`define PTR_UNLOCK_ALL 6'h00

// miss-cycle counter saturates above the largest threshold
`define MISS_CNT_W 3
`define MISS_CNT_SAT 3'h4
`define NV_ADDR_W 17

// pseudo-random generator seed and taps
`define LFSR_SEED 8'h5a
`define LFSR_TAPS 8'hb8

`endif

// ### hw/cache_tune_pkg.sv
/*
 * Types shared by the cache tuning and lock-stack block.
 * Assumes the constants header is available in hw/.
 */
package cache_tune_pkg;

	// sweep direction of the rebound replacement order
	typedef enum logic [0:0] {
		SWEEP_UP = 1'b0,
		SWEEP_DOWN = 1'b1
	} sweep_t;

endpackage

// ### hw/slot_victim_picker.sv
/*
 * Replacement slot picker: rebound sweep or pseudo-random choice,
 * confined to the unlocked slots at or below a limit.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`include "cache_tune_cfg.svh"

module slot_victim_picker (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic advance,
	input wire logic algoRandom,
	input wire logic [`SLOT_W-1:0] limit,
	output logic [`SLOT_W-1:0] victim
);

	cache_tune_pkg::sweep_t dir;
	cache_tune_pkg::sweep_t next_dir;
	logic [`SLOT_W-1:0] pos;
	logic [`SLOT_W-1:0] next_pos;
	logic [7:0] lfsr;
	logic [`SLOT_W-1:0] posClamped;
	logic [`SLOT_W-1:0] randSlot;

	////////////////////////////////////////////////////////////////////////
	// candidate slots
	assign posClamped = (pos > limit) ? limit : pos;
	assign randSlot = `SLOT_W'(lfsr[`SLOT_W-1:0] % ({1'b0, limit} + 7'd1));
	assign victim = algoRandom ? randSlot : posClamped;

	////////////////////////////////////////////////////////////////////////
	// rebound sweep: start to end, then end back to start
	always_comb begin
		next_dir = dir;
		next_pos = posClamped;
		unique case (dir)
			cache_tune_pkg::SWEEP_UP: begin
				if (posClamped >= limit) begin
					next_dir = cache_tune_pkg::SWEEP_DOWN;
					next_pos = (limit == `SLOT_ZERO) ? `SLOT_ZERO : limit - `SLOT_ONE;
				end else begin
					next_pos = posClamped + `SLOT_ONE;
				end
			end
			cache_tune_pkg::SWEEP_DOWN: begin
				if (posClamped == `SLOT_ZERO) begin
					next_dir = cache_tune_pkg::SWEEP_UP;
					next_pos = (limit == `SLOT_ZERO) ? `SLOT_ZERO : `SLOT_ONE;
				end else begin
					next_pos = posClamped - `SLOT_ONE;
				end
			end
		endcase
	end

	// sweep state moves only when a normal fill consumes a slot
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dir <= cache_tune_pkg::SWEEP_UP;
			pos <= `SLOT_ZERO;
		end else if (advance && !algoRandom) begin
			dir <= next_dir;
			pos <= next_pos;
		end
	end

	// free-running generator for the pseudo-random choice
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lfsr <= `LFSR_SEED;
		end else begin
			lfsr <= lfsr[0] ? ((lfsr >> 1) ^ `LFSR_TAPS) : (lfsr >> 1);
		end
	end

endmodule

// ### hw/branch_cache_tuning_lock.sv
/*
 * Tuning, lock-stack and miss-penalty diagnostics for a small branch
 * target cache in front of program flash, reached over the special
 * register port.
 * Assumes the core signals misses, fills and flash activity
 * synchronously to mclk, and that software keeps the lock stack sane.
 */
`timescale 1ns/10ps
`include "cache_tune_cfg.svh"

module branch_cache_tuning_lock (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	input wire logic missStall,
	input wire logic instrFill,
	input wire logic tableFill,
	input wire logic cacheWriteAllow,
	input wire logic nvBusy,
	input wire logic nvChange,
	input wire logic [`NV_ADDR_W-1:0] nvChangeAddr,
	output logic fillWrite,
	output logic [`SLOT_W-1:0] fillSlot,
	output logic fillPush,
	output logic invalidate,
	output logic [`NV_ADDR_W-1:0] invalidateAddr
);

	////////////////////////////////////////////////////////////////////////
	// state
	logic replaceAlgoSelect;
	logic tableReadFixedSlot;
	logic [1:0] missThreshold;
	logic lockPushEnable;
	logic [`SLOT_W-1:0] lockSlotPointer;
	logic [`ACC_W-1:0] missAcc;
	logic missAccOverflow;
	logic [3:0] missAccLowField;
	logic [`MISS_CNT_W-1:0] missCycles;

	logic [`ACC_W-1:0] next_missAcc;
	logic next_missAccOverflow;
	logic [`SLOT_W-1:0] next_lockSlotPointer;
	logic [`MISS_CNT_W-1:0] next_missCycles;

	////////////////////////////////////////////////////////////////////////
	// register decode
	wire selStatus = (sfrAddr == `OFS_FLASH_STATUS);
	wire selTuning = (sfrAddr == `OFS_CACHE_TUNING);
	wire selLock = (sfrAddr == `OFS_CACHE_LOCK_CONTROL);
	wire selAcc = (sfrAddr == `OFS_CACHE_MISS_ACC);
	wire wrTuning = sfrWrite && selTuning;
	wire wrLock = sfrWrite && selLock;
	wire wrAcc = sfrWrite && selAcc;
	wire rdAcc = sfrRead && selAcc;
	wire popReq = wrLock && sfrWdata[`LCK_POP_BIT];

	// reset images, sliced per field so no bits are dropped silently
	wire [7:0] rstTuning = `RST_CACHE_TUNING;
	wire [7:0] rstLock = `RST_CACHE_LOCK_CONTROL;

	////////////////////////////////////////////////////////////////////////
	// lock stack and fill decisions
	wire allUnlocked = (lockSlotPointer == `PTR_UNLOCK_ALL);
	wire [`SLOT_W-1:0] freeLimit = allUnlocked ? `SLOT_LAST : lockSlotPointer;
	wire pushNow = tableFill && lockPushEnable;
	wire missWorth = ({1'b0, missThreshold} < missCycles);
	wire instrTake = instrFill && cacheWriteAllow && missWorth;
	wire tableTake = tableFill && !lockPushEnable && cacheWriteAllow;
	wire normalTake = instrTake || (tableTake && !tableReadFixedSlot);
	wire [`SLOT_W-1:0] victim;

	// selected slot for the next write into cache memory
	wire [`SLOT_W-1:0] chosenSlot = pushNow ? lockSlotPointer :
		(tableTake && tableReadFixedSlot) ? `SLOT_ZERO : victim;

	slot_victim_picker picker (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.advance(normalTake),
		.algoRandom(replaceAlgoSelect),
		.limit(freeLimit),
		.victim(victim)
	);

	// push decrements, pop increments; both together cancel
	always_comb begin
		next_lockSlotPointer = lockSlotPointer;
		if (pushNow && !popReq) begin
			next_lockSlotPointer = lockSlotPointer - `SLOT_ONE;
		end else if (popReq && !pushNow) begin
			next_lockSlotPointer = lockSlotPointer + `SLOT_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stall cycles of the current miss, saturating above the threshold
	always_comb begin
		next_missCycles = missCycles;
		if (instrFill || tableFill) begin
			next_missCycles = '0;
		end else if (missStall && missCycles != `MISS_CNT_SAT) begin
			next_missCycles = missCycles + `MISS_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// miss-penalty accumulator
	wire accWrap = missStall && (missAcc == `ACC_MAX);

	always_comb begin
		next_missAcc = missAcc;
		next_missAccOverflow = missAccOverflow;
		if (wrAcc) begin
			next_missAcc = {sfrWdata[`MA_HIGH_HI:`MA_HIGH_LO], `ACC_CLR_BITS'(0)};
			next_missAccOverflow = 1'b0;
		end else if (missStall) begin
			next_missAcc = missAcc + `ACC_W'(1);
			next_missAccOverflow = missAccOverflow || accWrap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data
	wire [7:0] rdStatus = {7'h00, nvBusy};
	wire [7:0] rdTuning = {missAccLowField, replaceAlgoSelect, tableReadFixedSlot,
		missThreshold};
	wire [7:0] rdLock = {lockPushEnable, 1'b0, lockSlotPointer};
	wire [7:0] rdAcc8 = {missAccOverflow, missAcc[`ACC_HIGH_HI:`ACC_HIGH_LO]};
	wire [7:0] rdMux = selStatus ? rdStatus :
		selTuning ? rdTuning :
		selLock ? rdLock :
		selAcc ? rdAcc8 : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			replaceAlgoSelect <= rstTuning[`TUN_ALGO_BIT];
			tableReadFixedSlot <= rstTuning[`TUN_FIX_BIT];
			missThreshold <= rstTuning[`TUN_THR_HI:`TUN_THR_LO];
		end else if (wrTuning) begin
			replaceAlgoSelect <= sfrWdata[`TUN_ALGO_BIT];
			tableReadFixedSlot <= sfrWdata[`TUN_FIX_BIT];
			missThreshold <= sfrWdata[`TUN_THR_HI:`TUN_THR_LO];
		end
	end

	// lock stack registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lockPushEnable <= rstLock[`LCK_PUSH_BIT];
			lockSlotPointer <= rstLock[`LCK_PTR_HI:`LCK_PTR_LO];
		end else begin
			if (wrLock) begin
				lockPushEnable <= sfrWdata[`LCK_PUSH_BIT];
			end
			lockSlotPointer <= next_lockSlotPointer;
		end
	end

	// accumulator, overflow flag and latched low field
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			missAcc <= {`ACC_W{1'b0}};
			missAccOverflow <= 1'b0;
			missAccLowField <= 4'h0;
			missCycles <= '0;
		end else begin
			missAcc <= next_missAcc;
			missAccOverflow <= next_missAccOverflow;
			missCycles <= next_missCycles;
			if (rdAcc) begin
				missAccLowField <= missAcc[`ACC_LOWF_HI:`ACC_LOWF_LO];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs: read data, cache writes, invalidation
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sfrRdata <= 8'h00;
			fillWrite <= 1'b0;
			fillSlot <= `SLOT_ZERO;
			fillPush <= 1'b0;
			invalidate <= 1'b0;
			invalidateAddr <= '0;
		end else begin
			sfrRdata <= sfrRead ? rdMux : sfrRdata;
			fillWrite <= pushNow || instrTake || tableTake;
			fillSlot <= chosenSlot;
			fillPush <= pushNow;
			invalidate <= nvChange;
			invalidateAddr <= nvChange ? nvChangeAddr : invalidateAddr;
		end
	end

endmodule

// ### verif/core_fetch_model.sv
/*
 * Core fetch model: stalls for a requested count, then delivers a fill.
 * Assumes go is a one-cycle request set by the bench at a falling edge.
 */
`timescale 1ns/10ps
module core_fetch_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [5:0] nStall,
	input wire logic isTable,
	output logic missStall,
	output logic instrFill,
	output logic tableFill,
	output logic idle
);
	logic [5:0] left;
	logic kind;
	initial begin
		{missStall, instrFill, tableFill, kind} = 4'h0;
		idle = 1'b1;
		left = 6'h00;
	end
	// one stall cycle per count, then a one-cycle fill pulse
	// non-blocking so the bench reads go and idle without a race
	always @(negedge mclk) begin
		if (go) begin
			left <= nStall;
			kind <= isTable;
			idle <= 1'b0;
		end else if (!idle && left != 6'h00) begin
			missStall <= 1'b1;
			left <= left - 6'h01;
		end else if (!idle) begin
			missStall <= 1'b0;
			idle <= 1'b1;
		end
		instrFill <= !go && !idle && left == 6'h00 && !kind;
		tableFill <= !go && !idle && left == 6'h00 && kind;
	end
endmodule

// ### verif/branch_cache_tuning_lock_chk.sv
/*
 * Port checker for the cache tuning and lock-stack block.
 * Assumes it is bound onto branch_cache_tuning_lock.
 */
`timescale 1ns/10ps
module branch_cache_tuning_lock_chk (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	input wire logic instrFill,
	input wire logic tableFill,
	input wire logic cacheWriteAllow,
	input wire logic nvBusy,
	input wire logic nvChange,
	input wire logic [16:0] nvChangeAddr,
	input wire logic fillWrite,
	input wire logic [5:0] fillSlot,
	input wire logic fillPush,
	input wire logic invalidate,
	input wire logic [16:0] invalidateAddr
);
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	////////////////
	// shadow of the fixed-slot and push-enable bits
	logic fixBit;
	logic pushEn;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fixBit <= 1'b1;
			pushEn <= 1'b0;
		end else if (sfrWrite && sfrAddr == 8'ha2) begin
			fixBit <= sfrWdata[2];
		end else if (sfrWrite && sfrAddr == 8'ha3) begin
			pushEn <= sfrWdata[7];
		end
	end
	////////////////
	a_fill_cause: assert property (fillWrite |-> $past(instrFill || tableFill))
		else $error("stray fill");
	a_slot_range: assert property (fillWrite && !fillPush |-> fillSlot <= 6'h3e)
		else $error("slot out of range");
	a_fixed_slot: assert property (tableFill && fixBit && !pushEn && cacheWriteAllow
		|=> fillWrite && fillSlot == 6'h00) else $error("fixed slot missed");
	a_no_write: assert property (instrFill && !tableFill && !cacheWriteAllow |=> !fillWrite)
		else $error("fill while writes off");
	a_push_lock: assert property (tableFill && pushEn |=> fillWrite && fillPush)
		else $error("push not locked");
	a_pop_zero: assert property (sfrRead && sfrAddr == 8'ha3 |=> !sfrRdata[6])
		else $error("pop bit read high");
	a_busy_read: assert property (sfrRead && sfrAddr == 8'h88 |=> sfrRdata == {7'h00, $past(nvBusy)})
		else $error("busy status wrong");
	a_inv_follow: assert property (nvChange |=> invalidate && invalidateAddr == $past(nvChangeAddr))
		else $error("invalidate missed");
	a_inv_cause: assert property (invalidate |-> $past(nvChange))
		else $error("stray invalidate");
	// main scenarios
	c_push: cover property (tableFill && pushEn);
	c_inval: cover property (nvChange);
	c_fill: cover property (instrFill && cacheWriteAllow);
endmodule

bind branch_cache_tuning_lock branch_cache_tuning_lock_chk chk (.mclk, .sys_rst, .sfrAddr,
	.sfrWrite, .sfrRead, .sfrWdata, .sfrRdata, .instrFill, .tableFill, .cacheWriteAllow, .nvBusy,
	.nvChange, .nvChangeAddr, .fillWrite, .fillSlot, .fillPush, .invalidate, .invalidateAddr);

// ### verif/branch_cache_tuning_lock_tb.sv
/*
 * Self-checking bench for the cache tuning and lock-stack block.
 * Assumes the core model and the bound checker are compiled first.
 */
`timescale 1ns/10ps
module branch_cache_tuning_lock_tb;
	logic mclk = 1'b0;
	logic sys_rst, sfrWrite, sfrRead, cacheWriteAllow, nvBusy, nvChange, go, isTable, ovExp;
	logic missStall, instrFill, tableFill, idle, fillWrite, fillPush, invalidate;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata, fe;
	logic [16:0] nvChangeAddr, invalidateAddr;
	logic [5:0] fillSlot, nStall;
	logic [11:0] accExp;
	logic [3:0] tun;
	logic [31:0] seed, r;
	logic [7:0] rq[$], fq[$];
	logic [16:0] iq[$];
	int nErrors, samplesChecked;
	always #2.5 mclk = ~mclk;
	branch_cache_tuning_lock dut (.mclk, .sys_rst, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata,
		.sfrRdata, .missStall, .instrFill, .tableFill, .cacheWriteAllow, .nvBusy, .nvChange,
		.nvChangeAddr, .fillWrite, .fillSlot, .fillPush, .invalidate, .invalidateAddr);
	core_fetch_model core (.mclk, .go, .nStall, .isTable, .missStall, .instrFill, .tableFill, .idle);
	////////////////
	task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfrAddr = a;
		sfrWdata = d;
		sfrWrite = 1'b1;
		@(negedge mclk);
		sfrWrite = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		sfrAddr = a;
		sfrRead = 1'b1;
		rq.push_back(e);
		@(negedge mclk);
		sfrRead = 1'b0;
	endtask
	task automatic rdAcc;
		rd(8'h9a, {ovExp, accExp[11:5]});
		rd(8'ha2, {accExp[4:1], tun});
	endtask
	// stall n cycles, then fill; the accumulator note follows every stall cycle
	task automatic fetch(input logic [5:0] n, input logic t, input logic [7:0] e, input logic f);
		logic [12:0] s;
		s = accExp + n;
		ovExp = ovExp | s[12];
		accExp = s[11:0];
		if (f) fq.push_back(e);
		@(negedge mclk);
		go <= 1'b1;
		nStall <= n;
		isTable <= t;
		@(negedge mclk);
		go <= 1'b0;
		@(negedge mclk);
		for (int i = 0; i < 80 && !idle; i++) @(negedge mclk);
	endtask
	task automatic conclude;
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////
	// compare each result with the oldest note of its kind
	always @(posedge mclk) begin
		#1;
		if (sfrRead === 1'b1) chk("rdata", sfrRdata, rq.size() ? rq.pop_front() : 8'bx);
		if (invalidate === 1'b1) chk("inval", invalidateAddr, iq.size() ? iq.pop_front() : 17'bx);
		if (fillWrite === 1'b1) begin
			fe = fq.size() ? fq.pop_front() : 8'bx;
			if (fe[7] === 1'b0) chk("fill", {fillPush, fillSlot > 6'h3e}, 17'h0_0000);
			else chk("lock", {fillPush, fillSlot}, fe[6:0]);
		end
	end
	// watchdog
	initial begin
		#20000;
		nErrors++;
		conclude;
	end
	////////////////
	initial begin
		seed = 32'h45c5_ebe3;
		{sys_rst, sfrWrite, sfrRead, cacheWriteAllow, nvBusy, nvChange, go, isTable} = 8'h80;
		{sfrAddr, sfrWdata, nvChangeAddr, nStall} = '0;
		{nErrors, samplesChecked} = '0;
		accExp = 12'h000;
		ovExp = 1'b0;
		tun = 4'h4;
		repeat (10) @(negedge mclk);
		sys_rst = 1'b0;
		rd(8'h88, 8'h00);
		rd(8'ha2, 8'h04);
		rd(8'ha3, 8'h3e);
		rd(8'h9a, 8'h00);
		rd(8'h55, 8'h00);
		nvBusy = 1'b1;
		wr(8'h88, 8'h00);
		rd(8'h88, 8'h01);
		nvBusy = 1'b0;
		// flash changes with cache writes off
		repeat (2) begin
			r = $random(seed);
			@(negedge mclk);
			nvChange = 1'b1;
			nvChangeAddr = r[16:0];
			iq.push_back(r[16:0]);
			@(negedge mclk);
			nvChange = 1'b0;
		end
		cacheWriteAllow = 1'b1;
		fetch(6'h01, 1'b1, 8'h80, 1'b1);
		wr(8'ha2, 8'hf2);
		tun = 4'h2;
		for (int k = 1; k < 5; k++) fetch(k[5:0], 1'b0, {2'b10, 6'(k - 3)}, k > 2);
		wr(8'ha2, 8'h0a);
		tun = 4'ha;
		fetch(6'h04, 1'b0, 8'h00, 1'b1);
		cacheWriteAllow = 1'b0;
		wr(8'ha3, 8'h80);
		fetch(6'h00, 1'b1, 8'hfe, 1'b1);
		fetch(6'h00, 1'b1, 8'hfd, 1'b1);
		rd(8'ha3, 8'hbc);
		wr(8'ha3, 8'hc5); // pointer is below the top, so this pop is legal
		rd(8'ha3, 8'hbd);
		wr(8'ha3, 8'h00);
		fetch(6'h04, 1'b0, 8'h00, 1'b0);
		repeat (3) begin
			r = $random(seed);
			fetch(r[5:0], 1'b0, 8'h00, 1'b0);
		end
		rdAcc;
		wr(8'h9a, 8'h7f);
		accExp = 12'hfe0;
		fetch(6'h28, 1'b0, 8'h00, 1'b0);
		rdAcc;
		wr(8'h9a, 8'h05);
		accExp = 12'h0a0;
		ovExp = 1'b0;
		rdAcc;
		chk("pending", 17'(fq.size() + rq.size() + iq.size()), 17'h0_0000);
		conclude;
	end
endmodule
